// [sim/rcsc_chk.sv]
`timescale 1ns/1ps
module rcsc_chk
  import rcsc_pkg::*;
(
  // Inputs of the block
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire rcsc_src_t i_src,
  input wire logic [RCSC_AW-1:0] i_addr,
  input wire logic [RCSC_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  // Outputs of the block
  input wire logic o_rst_pin_out,
  input wire logic o_rst_pin_oe,
  input wire logic o_sys_rst,
  input wire logic o_clk_sel_ext,
  input wire logic o_int_osc_fast,
  input wire logic [RCSC_DW-1:0] o_rdata
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_src; i_src.supply_low || i_src.rst_pin_low |=> o_sys_rst;
  endproperty
  a_src: assert property (p_src) else $error("missed reset");
  property p_rel; o_sys_rst && i_src == '0 ##1 i_src == '0 |=> !o_sys_rst;
  endproperty
  a_rel: assert property (p_rel) else $error("reset stuck");
  property p_clk; o_sys_rst |-> !o_clk_sel_ext; endproperty
  a_clk: assert property (p_clk) else $error("clock not internal");
  property p_fast; o_int_osc_fast; endproperty
  a_fast: assert property (p_fast) else $error("slow osc");
  property p_od; o_rst_pin_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_por; i_src.supply_low |=> o_rst_pin_oe; endproperty
  a_por: assert property (p_por) else $error("pin not pulled");
  property p_nosw; !o_sys_rst && !$past(i_wr) |-> $stable(o_clk_sel_ext);
  endproperty
  a_nosw: assert property (p_nosw) else $error("clock moved");
  // A write just before may have armed a software reset
  property p_wr; !o_sys_rst && !$past(i_wr) && i_wr
    && i_addr == RCSC_ADDR_CLK && i_src == '0
    |=> o_clk_sel_ext == $past(i_wdata[0]); endproperty
  a_wr: assert property (p_wr) else $error("clock write lost");
endmodule : rcsc_chk
bind rcsc_top rcsc_chk chk (.i_clk_sys, .i_rst, .i_src, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rst_pin_out, .o_rst_pin_oe, .o_sys_rst, .o_clk_sel_ext,
  .o_int_osc_fast, .o_rdata);

// [sim/rcsc_pin_model.sv]
`timescale 1ns/1ps
// ----
// Board reset wire
// ----
module rcsc_pin_model (
  // Device side
  input wire logic i_oe,
  input wire logic i_out,
  // Board side
  input wire logic i_ext_low,
  output logic o_pin_low
);
  // Pulled up, so low only while someone sinks it
  assign o_pin_low = (i_oe && !i_out) || i_ext_low;
endmodule : rcsc_pin_model

// [sim/reset_and_clock_source_control_tb.sv]
`timescale 1ns/1ps
module reset_and_clock_source_control_tb;
  import rcsc_pkg::*;
  logic i_clk_sys = 0, i_rst = 1, i_wr = 0, i_rd = 0, ext_low = 0, pin_low;
  logic [3:0] i_addr = '0;
  logic [7:0] i_wdata = '0, o_rdata;
  logic o_rst_pin_out, o_rst_pin_oe, o_sys_rst, o_clk_sel_ext, o_int_osc_fast;
  rcsc_src_t src_d = '0, i_src;
  int mismatches = 0, tests_run = 0;
  typedef struct { rcsc_src_t src; logic rst; } rcsc_row_t;
  // Bit 0 of a row is the board pulling the pin; cnv is masked at reset
  rcsc_row_t rows[6] = '{'{6'h20, 1}, '{6'h10, 1}, '{6'h08, 1},
    '{6'h04, 1}, '{6'h02, 0}, '{6'h01, 1}};
  always_comb begin
    i_src = src_d;
    i_src.rst_pin_low = pin_low;
  end
  rcsc_top #(.POR_OUT_CYC(2)) uut (.i_clk_sys, .i_rst, .i_src, .o_rst_pin_out,
    .o_rst_pin_oe, .o_sys_rst, .o_clk_sel_ext, .o_int_osc_fast, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata);
  rcsc_pin_model pin (.i_oe(o_rst_pin_oe), .i_out(o_rst_pin_out),
    .i_ext_low(ext_low), .o_pin_low(pin_low));
  initial forever #25 i_clk_sys = ~i_clk_sys;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk_sys) i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk_sys) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys) i_rd <= 1'b0;
    @(negedge i_clk_sys) chk(o_rdata, e);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cyc
  task automatic rel;
    for (int k = 0; k < 20 && o_sys_rst !== 1'b0; k++) @(negedge i_clk_sys);
    chk({7'h00, o_sys_rst}, 8'h00);
  endtask : rel
  task automatic conclude;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #200us;
    mismatches++;
    conclude();
  end
  initial begin
    cyc(16);
    i_rst <= 1'b0;
    @(negedge i_clk_sys) chk({7'h00, o_rst_pin_oe}, 8'h01);
    rel();
    rd(RCSC_ADDR_SRC_EN, {3'h0, RCSC_SRC_EN_RST});
    foreach (rows[i]) begin
      @(posedge i_clk_sys) {src_d, ext_low} <= {rows[i].src & 6'h3E,
        rows[i].src[0]};
      cyc(3);
      @(negedge i_clk_sys) chk({7'h00, o_sys_rst}, {7'h00, rows[i].rst});
      @(posedge i_clk_sys) {src_d, ext_low} <= '0;
      rel();
      $display("row %0d done", i);
    end
    wr(RCSC_ADDR_CLK, 8'h01);
    @(negedge i_clk_sys) chk({7'h00, o_clk_sel_ext}, 8'h01);
    wr(RCSC_ADDR_SWRST, 8'h00);
    cyc(2);
    @(negedge i_clk_sys) chk({o_sys_rst, o_clk_sel_ext}, 8'h01);
    wr(RCSC_ADDR_SWRST, RCSC_SWRST_KEY);
    // Soft reset lasts one cycle once armed
    cyc(1);
    @(negedge i_clk_sys) chk({o_sys_rst, o_clk_sel_ext}, 8'h02);
    rel();
    rd(RCSC_ADDR_CAUSE, 8'h01 << RCSC_B_SW);
    $display("clock switch done");
    wr(RCSC_ADDR_SRC_EN, 8'h00);
    @(posedge i_clk_sys) src_d.watchdog_unit <= 1'b1;
    cyc(3);
    @(negedge i_clk_sys) chk({7'h00, o_sys_rst}, 8'h00);
    @(posedge i_clk_sys) src_d <= '0;
    wr(RCSC_ADDR_WDOG, RCSC_WDOG_LOCK_KEY);
    wr(RCSC_ADDR_SRC_EN, 8'h00);
    rd(RCSC_ADDR_WDOG, 8'h01);
    @(posedge i_clk_sys) src_d.watchdog_unit <= 1'b1;
    cyc(3);
    @(negedge i_clk_sys) chk({7'h00, o_sys_rst}, 8'h01);
    @(posedge i_clk_sys) src_d <= '0;
    rel();
    rd(4'hF, 8'h00);
    $display("lock done");
    conclude();
  end
endmodule : reset_and_clock_source_control_tb

// [verilog/rcsc_pkg.sv]
package rcsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int RCSC_AW = 4;
  localparam int RCSC_DW = 8;
  localparam logic [3:0] RCSC_ADDR_SRC_EN = 4'h0;
  localparam logic [3:0] RCSC_ADDR_CLK = 4'h1;
  localparam logic [3:0] RCSC_ADDR_WDOG = 4'h2;
  localparam logic [3:0] RCSC_ADDR_CAUSE = 4'h3;
  localparam logic [3:0] RCSC_ADDR_SWRST = 4'h4;

  // Source enable bit positions
  localparam int RCSC_B_WDOG = 0;
  localparam int RCSC_B_MCLK = 1;
  localparam int RCSC_B_CMP = 2;
  localparam int RCSC_B_SW = 3;
  localparam int RCSC_B_CNV = 4;
  localparam int RCSC_NSRC = 5;

  // Cause bits: the five gated sources then supply monitor, pin
  localparam int RCSC_B_SUPPLY = 5;
  localparam int RCSC_B_PIN = 6;
  localparam int RCSC_NCAUSE = 7;

  localparam logic [4:0] RCSC_SRC_EN_RST = 5'h0F;
  // Cause after a hard reset reads as a supply event
  localparam logic [6:0] RCSC_CAUSE_RST = 7'h20;
  localparam logic [7:0] RCSC_SWRST_KEY = 8'hA5;
  localparam logic [7:0] RCSC_WDOG_LOCK_KEY = 8'h5A;
  localparam int RCSC_CLK_SEL_BIT = 0;
  localparam int RCSC_WDOG_LOCK_BIT = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RCSC_CLK_HZ = 20_000_000;
  localparam int RCSC_INT_OSC_MAX_HZ = 16_000_000;
  localparam int RCSC_POR_OUT_NS = 1000;
  localparam int RCSC_POR_OUT_CYC =
    (RCSC_POR_OUT_NS * (RCSC_CLK_HZ / 1_000_000) + 999) / 1000;

  typedef enum logic [1:0] {
    RCSC_CLK_INT = 2'b00,
    RCSC_CLK_EXT = 2'b01
  } rcsc_clk_t;

  typedef enum logic [1:0] {
    RCSC_ST_RESET = 2'b00,
    RCSC_ST_RUN = 2'b01
  } rcsc_state_t;

  typedef struct packed {
    logic supply_low;
    logic watchdog_unit;
    logic missing_clk;
    logic cmp_level;
    logic conversion_start_pin;
    logic rst_pin_low;
  } rcsc_src_t;

  typedef struct packed {
    rcsc_state_t state;
    logic [RCSC_NSRC-1:0] src_en;
    logic wdog_locked;
    logic sw_req;
    rcsc_clk_t clk_sel;
    logic [RCSC_NCAUSE-1:0] cause;
    logic [7:0] por_cnt;
    logic rst_out;
    logic [RCSC_DW-1:0] rdata;
  } rcsc_st_t;

endpackage : rcsc_pkg

// [verilog/rcsc_top.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Overview of operation
// - Seven sources reset: supply, watchdog, clock loss, comparator, sw, pins.
// - Reset pin is bidirectional; device drives its power-on reset out.
// - All sources maskable except supply monitor and reset pin.
// - After power-on, software may lock watchdog enabled permanently.
// - Any reset selects internal oscillator as system clock.
// - Software switches internal/external oscillator without reset.
// - Internal oscillator offers fast clock up to 16 MHz.
// ------------------------------------------------------------------
module rcsc_top
  import rcsc_pkg::*;
#(
  parameter int POR_OUT_CYC = RCSC_POR_OUT_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Reset sources
  input wire rcsc_src_t i_src,
  // Reset pin output driver, open drain low
  output logic o_rst_pin_out,
  output logic o_rst_pin_oe,
  // System outputs
  output logic o_sys_rst,
  output logic o_clk_sel_ext,
  output logic o_int_osc_fast,
  // Register port
  input wire logic [RCSC_AW-1:0] i_addr,
  input wire logic [RCSC_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [RCSC_DW-1:0] o_rdata
);

  rcsc_st_t st_reg;
  rcsc_st_t st_next;
  logic [RCSC_NCAUSE-1:0] active;
  logic any_active;
  logic [RCSC_NSRC-1:0] eff_en;

  // ----------------------------------------------------------------
  // Source combining
  // ----------------------------------------------------------------
  always_comb begin
    eff_en = st_reg.src_en;
    eff_en[RCSC_B_WDOG] = st_reg.src_en[RCSC_B_WDOG]
      | st_reg.wdog_locked;
    active[RCSC_B_WDOG] = i_src.watchdog_unit & eff_en[RCSC_B_WDOG];
    active[RCSC_B_MCLK] = i_src.missing_clk & eff_en[RCSC_B_MCLK];
    active[RCSC_B_CMP] = i_src.cmp_level & eff_en[RCSC_B_CMP];
    active[RCSC_B_SW] = st_reg.sw_req & eff_en[RCSC_B_SW];
    active[RCSC_B_CNV] =
      i_src.conversion_start_pin & eff_en[RCSC_B_CNV];
    // Never maskable
    active[RCSC_B_SUPPLY] = i_src.supply_low;
    active[RCSC_B_PIN] = i_src.rst_pin_low;
    any_active = |active;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.sw_req = 1'b0;
    st_next.rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        RCSC_ADDR_SRC_EN: st_next.rdata = RCSC_DW'(st_reg.src_en);
        RCSC_ADDR_CLK: st_next.rdata = RCSC_DW'(st_reg.clk_sel);
        RCSC_ADDR_WDOG: st_next.rdata = RCSC_DW'(st_reg.wdog_locked);
        RCSC_ADDR_CAUSE: st_next.rdata = RCSC_DW'(st_reg.cause);
        default: st_next.rdata = '0;
      endcase
    end
    if (i_wr && st_reg.state == RCSC_ST_RUN) begin
      unique case (i_addr)
        RCSC_ADDR_SRC_EN: begin
          st_next.src_en = i_wdata[RCSC_NSRC-1:0];
        end
        RCSC_ADDR_CLK: begin
          st_next.clk_sel = i_wdata[RCSC_CLK_SEL_BIT] ?
            RCSC_CLK_EXT : RCSC_CLK_INT;
        end
        RCSC_ADDR_WDOG: begin
          // Lock only once, sticky until the next power-on
          if (i_wdata == RCSC_WDOG_LOCK_KEY) begin
            st_next.wdog_locked = 1'b1;
          end
        end
        RCSC_ADDR_SWRST: begin
          st_next.sw_req = (i_wdata == RCSC_SWRST_KEY);
        end
        default: ;
      endcase
    end
    if (st_reg.por_cnt != '0) begin
      st_next.por_cnt = st_reg.por_cnt - 8'h01;
    end
    st_next.rst_out = (st_reg.por_cnt != '0) | i_src.supply_low;
    unique case (st_reg.state)
      RCSC_ST_RESET: begin
        st_next.clk_sel = RCSC_CLK_INT;
        st_next.sw_req = 1'b0;
        if (!any_active) begin
          st_next.state = RCSC_ST_RUN;
        end
      end
      RCSC_ST_RUN: begin
        if (any_active) begin
          st_next.state = RCSC_ST_RESET;
          st_next.cause = active;
          st_next.clk_sel = RCSC_CLK_INT;
        end
      end
      default: st_next.state = RCSC_ST_RESET;
    endcase
    // Supply loss counts as power-on: clears the watchdog lock
    if (i_src.supply_low) begin
      st_next.wdog_locked = 1'b0;
      st_next.src_en = RCSC_SRC_EN_RST;
      st_next.por_cnt = 8'(POR_OUT_CYC);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_reg.state <= RCSC_ST_RESET;
      st_reg.src_en <= RCSC_SRC_EN_RST;
      st_reg.wdog_locked <= 1'b0;
      st_reg.sw_req <= 1'b0;
      st_reg.clk_sel <= RCSC_CLK_INT;
      st_reg.cause <= RCSC_CAUSE_RST;
      st_reg.por_cnt <= 8'(POR_OUT_CYC);
      st_reg.rst_out <= 1'b1;
      st_reg.rdata <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pin is pulled low only while driven; no high drive
  assign o_rst_pin_out = 1'b0;
  assign o_rst_pin_oe = st_reg.rst_out;
  assign o_sys_rst = (st_reg.state == RCSC_ST_RESET);
  assign o_clk_sel_ext = (st_reg.clk_sel == RCSC_CLK_EXT);
  // Fast internal clock always offered; divider sits outside
  assign o_int_osc_fast = (RCSC_INT_OSC_MAX_HZ > 0);
  assign o_rdata = st_reg.rdata;

endmodule : rcsc_top
